/* common/link_tx_consts.vh */
// Constants for the serial link transmit framer
// Assumes inclusion by bare name from design files
`ifndef LINK_TX_CONSTS_VH
`define LINK_TX_CONSTS_VH
`define CH_START_MF 8'h1c
`define CH_LANE_ALIGN 8'h7c
`define CH_CFG_MARK 8'h9c
`define CH_COMMA 8'hbc
`define CH_FRAME_ALIGN 8'hfc
`define USER_FA_VAL 8'hfc
`define USER_LA_VAL 8'hfd
`define ILAS_MF_COUNT 2'h3
`define CFG_FIRST_POS 8'h02
`define CFG_OCTETS 8'h0e
`define SCR_SEED 15'h7fff
`define SYNC_RESYNC_FRAMES 8'h05
`endif

/* rtl/enc_8b10b.v */
// 8b/10b encoder with running disparity, bypass and invert
// Assumes one octet per clock, code selects K or D
`timescale 1ns/1ps
`default_nettype none
module enc_8b10b (
	input wire clk,
	input wire reset_n,
	input wire [7:0] octet,
	input wire is_k,
	input wire bypass,
	input wire invert,
	output reg [9:0] symbol_r
);
	reg rd_r;
	reg [5:0] six;
	reg [3:0] four;
	reg rd_mid;
	reg rd_nxt;
	reg [9:0] code;
	integer ones6;
	integer ones4;

	// ************************************************************
	// 5b/6b and 3b/4b tables
	// ************************************************************
	function [5:0] tab6;
		input [4:0] v;
		begin
			case (v)
				5'd0: tab6 = 6'b100111; 5'd1: tab6 = 6'b011101; 5'd2: tab6 = 6'b101101;
				5'd3: tab6 = 6'b110001; 5'd4: tab6 = 6'b110101; 5'd5: tab6 = 6'b101001;
				5'd6: tab6 = 6'b011001; 5'd7: tab6 = 6'b111000; 5'd8: tab6 = 6'b111001;
				5'd9: tab6 = 6'b100101; 5'd10: tab6 = 6'b010101; 5'd11: tab6 = 6'b110100;
				5'd12: tab6 = 6'b001101; 5'd13: tab6 = 6'b101100; 5'd14: tab6 = 6'b011100;
				5'd15: tab6 = 6'b010111; 5'd16: tab6 = 6'b011011; 5'd17: tab6 = 6'b100011;
				5'd18: tab6 = 6'b010011; 5'd19: tab6 = 6'b110010; 5'd20: tab6 = 6'b001011;
				5'd21: tab6 = 6'b101010; 5'd22: tab6 = 6'b011010; 5'd23: tab6 = 6'b111010;
				5'd24: tab6 = 6'b110011; 5'd25: tab6 = 6'b100110; 5'd26: tab6 = 6'b010110;
				5'd27: tab6 = 6'b110110; 5'd28: tab6 = 6'b001110; 5'd29: tab6 = 6'b101110;
				5'd30: tab6 = 6'b011110; default: tab6 = 6'b101011;
			endcase
		end
	endfunction

	function [3:0] tab4;
		input [2:0] v;
		input k;
		begin
			case (v)
				3'd0: tab4 = 4'b1011;
				3'd1: tab4 = k ? 4'b0110 : 4'b1001;
				3'd2: tab4 = k ? 4'b1010 : 4'b0101;
				3'd3: tab4 = 4'b1100;
				3'd4: tab4 = 4'b1101;
				3'd5: tab4 = k ? 4'b0101 : 4'b1010;
				3'd6: tab4 = k ? 4'b1001 : 4'b0110;
				default: tab4 = k ? 4'b0111 : 4'b1110;
			endcase
		end
	endfunction

	function integer ones;
		input [5:0] v;
		integer i;
		begin
			ones = 0;
			for (i = 0; i < 6; i = i + 1) begin
				ones = ones + v[i];
			end
		end
	endfunction

	// ************************************************************
	// Disparity-driven symbol choice
	// ************************************************************
	always @* begin
		six = is_k ? 6'b001111 : tab6(octet[4:0]);
		ones6 = ones(six);
		if (!rd_r && ones6 < 3) begin
			six = ~six;
		end else if (rd_r && ones6 > 3) begin
			six = ~six;
		end else if (ones6 == 3 && six == 6'b111000 && rd_r) begin
			six = ~six;
		end else if (ones6 == 3 && six == 6'b000111 && !rd_r) begin
			six = ~six;
		end
		ones6 = ones(six);
		rd_mid = (ones6 == 3) ? rd_r : (ones6 > 3);
		four = tab4(octet[7:5], is_k);
		if (!is_k && octet[7:5] == 3'd7 && ((!rd_mid && (octet[4:0] == 5'd17 || octet[4:0] == 5'd18 ||
			octet[4:0] == 5'd20)) || (rd_mid && (octet[4:0] == 5'd11 || octet[4:0] == 5'd13 ||
			octet[4:0] == 5'd14)))) begin
			four = 4'b0111;
		end
		ones4 = ones({2'b00, four});
		if ((!rd_mid && ones4 < 2) || (rd_mid && ones4 > 2)) begin
			four = ~four;
		end else if (ones4 == 2 && four == 4'b1100 && rd_mid) begin
			four = ~four;
		end else if (ones4 == 2 && four == 4'b0011 && !rd_mid) begin
			four = ~four;
		end else if (is_k && ones4 == 2 && rd_mid) begin
			four = ~four;
		end
		if (four == 4'b1110 && rd_mid) begin
			four = 4'b0001;
		end
		ones4 = ones({2'b00, four});
		rd_nxt = (ones4 == 2) ? rd_mid : (ones4 > 2);
		code = {six, four};
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_r <= 1'b0;
			symbol_r <= 10'h000;
		end else begin
			if (!bypass) begin
				rd_r <= rd_nxt;
			end
			if (bypass) begin
				symbol_r <= invert ? ~{is_k, 1'b0, octet} : {is_k, 1'b0, octet};
			end else begin
				symbol_r <= invert ? ~code : code;
			end
		end
	end
endmodule
`default_nettype wire

/* rtl/serial_link_tx_sync_framer.v */
// Transmit link layer: tail fill, sync, alignment sequence, char insertion, scrambling
// Assumes octet-wide lanes, one octet per clock per lane, LMFC marked by frame counters here
// Functional notes
// - Tail bits fill word below sample and control
// - Only comma characters during code group sync
// - Low sync request keeps commas flowing
// - Alignment sequence starts at next multiframe boundary
// - Four multiframes, start and lane-align characters
// - First multiframe carries ramp after start
// - Second multiframe: marker then 14 config octets
// - Undefined alignment octets carry ramp data
// - Alignment sequence never scrambled
// - After fourth multiframe send user data
// - Scrambled 0xfc at frame end becomes frame-align
// - Scrambled 0xfd at multiframe end becomes lane-align
// - Unscrambled repeated frame end octet replaced
// - Scrambling on after reset, software switchable
// - Character insertion on after reset, switchable
// - Control characters use fixed octet codes
// - Encoder picks symbol by running disparity
// - Encoder bypass and invert debug options
// - Sync input differential default, selectable modes
// - Lane outputs one 10-bit symbol per clock, powered after reset
// - Self-synchronizing scrambler 1+x^14+x^15
`timescale 1ns/1ps
`default_nettype none
`include "link_tx_consts.vh"
module serial_link_tx_sync_framer #(
	parameter F = 2,
	parameter K = 32,
	parameter NP = 16,
	parameter N = 14,
	parameter CS = 0
) (
	input wire clk,
	input wire reset_n,
	input wire [N-1:0] sample,
	input wire [CS:0] ctrl_bits,
	input wire sync_request_n,
	input wire sync_request_se,
	input wire sync_sel_single_ended,
	input wire sync_sw_override,
	input wire sync_sw_value_n,
	input wire scramble_disable,
	input wire align_char_insert_disable,
	input wire [1:0] enc_debug,
	input wire [111:0] cfg_octets,
	input wire lane_power_down,
	output reg [9:0] lane_symbol_r,
	output reg lane_enable_r,
	output reg [2:0] link_state_r
);
	localparam TAIL = NP - N - CS;
	localparam [NP-1:0] TAIL_MASK = {NP{1'b1}} >> (NP - TAIL);
	localparam [2:0] ST_CGS = 3'b001;
	localparam [2:0] ST_ILAS = 3'b010;
	localparam [2:0] ST_DATA = 3'b100;

	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [7:0] oct_r;
	reg [7:0] frm_r;
	reg [1:0] mf_r;
	reg [7:0] ramp_r;
	reg [14:0] scr_r;
	reg [7:0] prev_last_r;
	reg [7:0] low_cnt_r;
	reg [NP-1:0] word;
	reg [7:0] raw;
	reg [7:0] tx_oct;
	reg tx_k;
	reg [7:0] scr_oct;
	reg [14:0] scr_nxt;
	wire sync_n;
	wire frame_end;
	wire mf_end;
	wire [9:0] enc_sym;
	integer i;
	integer j;

	// ************************************************************
	// Sync request source selection
	// ************************************************************
	assign sync_n = sync_sw_override ? sync_sw_value_n :
		(sync_sel_single_ended ? sync_request_se : sync_request_n);
	assign frame_end = (oct_r == F - 1);
	assign mf_end = frame_end && (frm_r == K - 1);

	// ************************************************************
	// Transport: sample plus control plus tail into octets
	// ************************************************************
	always @* begin
		word = {NP{1'b0}};
		word[NP-1 -: N] = sample;
		for (j = 0; j < CS; j = j + 1) begin
			word[NP-1-N-j] = ctrl_bits[CS-1-j];
		end
		word = word & ~TAIL_MASK;
		raw = word[NP-1-8*(oct_r % (NP/8)) -: 8];
	end

	// ************************************************************
	// Scrambler
	// ************************************************************
	always @* begin
		scr_nxt = scr_r;
		for (i = 7; i >= 0; i = i - 1) begin
			scr_oct[i] = raw[i] ^ scr_nxt[13] ^ scr_nxt[14];
			scr_nxt = {scr_nxt[13:0], scr_oct[i]};
		end
	end

	// ************************************************************
	// Octet selection per link state
	// ************************************************************
	always @* begin
		tx_oct = `CH_COMMA;
		tx_k = 1'b1;
		state_nxt = state_r;
		case (state_r)
			ST_CGS: begin
				tx_oct = `CH_COMMA;
				tx_k = 1'b1;
				if (sync_n && mf_end) begin
					state_nxt = ST_ILAS;
				end
			end
			ST_ILAS: begin
				tx_oct = ramp_r;
				tx_k = 1'b0;
				if (oct_r == 8'h00 && frm_r == 8'h00) begin
					tx_oct = `CH_START_MF;
					tx_k = 1'b1;
				end else if (mf_end) begin
					tx_oct = `CH_LANE_ALIGN;
					tx_k = 1'b1;
				end else if (mf_r == 2'h1 && frm_r == 8'h00 && oct_r == 8'h01) begin
					tx_oct = `CH_CFG_MARK;
					tx_k = 1'b1;
				end else if (mf_r == 2'h1) begin
					if (frm_r * F + oct_r >= `CFG_FIRST_POS && frm_r * F + oct_r < `CFG_FIRST_POS + `CFG_OCTETS) begin
						tx_oct = cfg_octets[8*(frm_r*F+oct_r-`CFG_FIRST_POS) +: 8];
					end
				end
				if (!sync_n) begin
					state_nxt = ST_CGS;
				end else if (mf_end && mf_r == `ILAS_MF_COUNT) begin
					state_nxt = ST_DATA;
				end
			end
			ST_DATA: begin
				tx_oct = scramble_disable ? raw : scr_oct;
				tx_k = 1'b0;
				if (!align_char_insert_disable && frame_end) begin
					if (!scramble_disable) begin
						if (mf_end && scr_oct == `USER_LA_VAL) begin
							tx_oct = `CH_LANE_ALIGN;
							tx_k = 1'b1;
						end else if (scr_oct == `USER_FA_VAL) begin
							tx_oct = `CH_FRAME_ALIGN;
							tx_k = 1'b1;
						end
					end else if (raw == prev_last_r) begin
						tx_oct = mf_end ? `CH_LANE_ALIGN : `CH_FRAME_ALIGN;
						tx_k = 1'b1;
					end
				end
				if (low_cnt_r >= `SYNC_RESYNC_FRAMES * F) begin
					state_nxt = ST_CGS;
				end
			end
			default: begin
				state_nxt = ST_CGS;
			end
		endcase
	end

	// ************************************************************
	// Counters and state
	// ************************************************************
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_CGS;
			oct_r <= 8'h00;
			frm_r <= 8'h00;
			mf_r <= 2'h0;
			ramp_r <= 8'h00;
			scr_r <= `SCR_SEED;
			prev_last_r <= 8'h00;
			low_cnt_r <= 8'h00;
			lane_enable_r <= 1'b0;
			link_state_r <= ST_CGS;
		end else begin
			state_r <= state_nxt;
			link_state_r <= state_nxt;
			lane_enable_r <= !lane_power_down;
			oct_r <= frame_end ? 8'h00 : oct_r + 8'h01;
			if (frame_end) begin
				frm_r <= mf_end ? 8'h00 : frm_r + 8'h01;
			end
			if (state_r == ST_ILAS) begin
				ramp_r <= ramp_r + 8'h01;
				if (mf_end) begin
					mf_r <= mf_r + 2'h1;
				end
			end else begin
				ramp_r <= 8'h00;
				mf_r <= 2'h0;
			end
			if (state_r == ST_DATA && !scramble_disable) begin
				scr_r <= scr_nxt;
			end
			if (state_r == ST_DATA && frame_end) begin
				prev_last_r <= raw;
			end
			if (sync_n || state_r != ST_DATA) begin
				low_cnt_r <= 8'h00;
			end else if (low_cnt_r != 8'hff) begin
				low_cnt_r <= low_cnt_r + 8'h01;
			end
		end
	end

	// ************************************************************
	// Encoder and output register
	// ************************************************************
	enc_8b10b u_enc (
		.clk(clk),
		.reset_n(reset_n),
		.octet(tx_oct),
		.is_k(tx_k),
		.bypass(enc_debug[0]),
		.invert(enc_debug[1]),
		.symbol_r(enc_sym)
	);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lane_symbol_r <= 10'h000;
		end else begin
			lane_symbol_r <= enc_sym;
		end
	end
endmodule
`default_nettype wire

/* verification/serial_link_tx_sync_framer_assertions.sv */
// Checker for the serial link transmit framer
// Assumes binding to the framer top module ports
`timescale 1ns/1ps
`default_nettype none
module link_tx_checker #(
	parameter int F = 2,
	parameter int K = 32
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sync_request_n,
	input wire logic sync_request_se,
	input wire logic sync_sel_single_ended,
	input wire logic sync_sw_override,
	input wire logic sync_sw_value_n,
	input wire logic [1:0] enc_debug,
	input wire logic lane_power_down,
	input wire logic [9:0] lane_symbol_r,
	input wire logic lane_enable_r,
	input wire logic [2:0] link_state_r
);
	// ****
	// Helpers
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire sel_sync = sync_sel_single_ended ? sync_request_se : sync_request_n;
	wire eff = sync_sw_override ? sync_sw_value_n : sel_sync;
	int ilas_cnt;
	int ph;
	int ph0;
	int low_cnt;
	logic seen;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ilas_cnt <= 0;
			ph <= 0;
			ph0 <= 0;
			low_cnt <= 0;
			seen <= 1'h0;
		end else begin
			ilas_cnt <= link_state_r[1] ? ilas_cnt + 1 : 0;
			ph <= (ph == F * K - 1) ? 0 : ph + 1;
			low_cnt <= eff ? 0 : (low_cnt < 255 ? low_cnt + 1 : low_cnt);
			if (link_state_r[1] && !seen) begin
				seen <= 1'h1;
				ph0 <= ph;
			end
		end
	end
	// ****
	// Assertions
	// ****
	AST_ONEHOT: assert property ($onehot(link_state_r)) else $error("state not one-hot");
	AST_CGS_COMMA: assert property (link_state_r[0] && $past(link_state_r[0]) && $past(link_state_r[0], 2)
		&& $past(reset_n, 3) && enc_debug == 2'h1 && $past(enc_debug, 2) == 2'h1 |-> lane_symbol_r == 10'h2bc)
		else $error("non-comma in sync phase");
	AST_ILAS_ABORT: assert property (link_state_r[1] && !eff |=> link_state_r[0]) else $error("no abort");
	AST_ILAS_LEN: assert property ($rose(link_state_r[2]) |-> ilas_cnt == 4 * F * K)
		else $error("alignment length wrong");
	AST_ILAS_PHASE: assert property ($rose(link_state_r[1]) && seen |-> ph == ph0)
		else $error("alignment off boundary");
	AST_RESYNC_LATE: assert property (link_state_r[2] |-> low_cnt <= 5 * F + 1) else $error("resync late");
	AST_RESYNC_EARLY: assert property ($fell(link_state_r[2]) |-> $past(low_cnt) >= 5 * F)
		else $error("resync early");
	AST_LANE_EN: assert property ($past(reset_n) |-> lane_enable_r == !$past(lane_power_down))
		else $error("lane enable wrong");
	C_ILAS: cover property ($rose(link_state_r[1]));
	C_DATA: cover property ($rose(link_state_r[2]));
	C_RESYNC: cover property ($fell(link_state_r[2]));
endmodule
bind serial_link_tx_sync_framer link_tx_checker #(.F(F), .K(K)) u_chk (.*);
`default_nettype wire

/* verification/link_rx_model.sv */
// Receiver model: sync request from comma count
// Assumes symbols in bypass or normal encoding
`timescale 1ns/1ps
`default_nettype none
module link_rx_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [9:0] symbol,
	input wire logic force_low,
	output logic sync_n
);
	logic [2:0] good;
	wire comma = symbol == 10'h2bc || symbol == 10'h0fa || symbol == 10'h305;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			good <= 3'h0;
			sync_n <= 1'h0;
		end else if (force_low) begin
			good <= 3'h0;
			sync_n <= 1'h0;
		end else if (!sync_n) begin
			good <= comma ? good + 3'h1 : 3'h0;
			if (comma && good == 3'h3)
				sync_n <= 1'h1;
		end
	end
endmodule
`default_nettype wire

/* verification/serial_link_tx_sync_framer_tb.sv */
// Testbench for the serial link transmit framer
// Assumes bypass encoding for octet checks, K=16 F=2
`timescale 1ns/1ps
`default_nettype none
`include "link_tx_consts.vh"
module serial_link_tx_sync_framer_tb;
	localparam int MF = 32;
	localparam logic [9:0] s_r = 10'h21c, s_a = 10'h27c, s_q = 10'h29c, s_k = 10'h2bc, s_f = 10'h2fc;
	logic clk = 0, reset_n = 0, sel = 0, force_low = 0, ovr = 0, ovr_n = 1;
	logic scr_dis = 0, ins_dis = 0, pdn = 0;
	logic [1:0] dbg = 2'h1;
	logic [13:0] sample = 14'h1234;
	logic [111:0] cfg = 112'h0;
	wire [9:0] sym;
	wire en;
	wire [2:0] st;
	wire sync_m;
	logic [9:0] q [0:191];
	int failures = 0, total_checks = 0;
	always #5 clk = ~clk;
	link_rx_model u_rx (.clk(clk), .reset_n(reset_n), .symbol(sym), .force_low(force_low), .sync_n(sync_m));
	serial_link_tx_sync_framer #(.F(2), .K(16)) u_dut (.clk(clk), .reset_n(reset_n), .sample(sample),
		.ctrl_bits(1'h0), .sync_request_n(sel ? 1'h1 : sync_m), .sync_request_se(sel ? sync_m : 1'h1),
		.sync_sel_single_ended(sel), .sync_sw_override(ovr), .sync_sw_value_n(ovr_n),
		.scramble_disable(scr_dis), .align_char_insert_disable(ins_dis), .enc_debug(dbg),
		.cfg_octets(cfg), .lane_power_down(pdn), .lane_symbol_r(sym), .lane_enable_r(en), .link_state_r(st));
	// ****
	// Tasks
	// ****
	task automatic end_sim;
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic link_up(input bit dat);
		int n;
		logic [7:0] o;
		logic [14:0] ss;
		logic [9:0] e;
		n = 0;
		while (sym !== s_r && n < 400) begin
			step(1);
			n++;
		end
		if (n == 400) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, sym, s_r);
			end_sim;
		end
		for (int i = 0; i < 192; i++) begin
			q[i] = sym;
			step(1);
		end
		for (int m = 0; m < 4; m++) begin
			chk(q[MF * m], s_r);
			chk(q[MF * m + MF - 1], s_a);
			for (int i = 1; i < MF - 2 && m != 1; i++)
				chk(q[i + 1 + MF * m], q[i + MF * m] + 10'h1);
		end
		chk(q[MF + 1], s_q);
		for (int i = 0; i < 14; i++)
			chk(q[MF + 2 + i], {2'h0, cfg[8 * i +: 8]});
		for (int f = 1; f < 32 && dat; f++) begin
			chk(q[128 + 2 * f], {2'h0, sample[13:6]});
			chk(q[129 + 2 * f], !ins_dis ? (f % 16 == 15 ? s_a : s_f) : {2'h0, sample[5:0], 2'h0});
		end
		ss = `SCR_SEED;
		for (int i = 128; i < 192 && !dat; i++) begin
			o = (i % 2 == 0) ? sample[13:6] : {sample[5:0], 2'h0};
			for (int b = 7; b >= 0; b--) begin
				o[b] = o[b] ^ ss[13] ^ ss[14];
				ss = {ss[13:0], o[b]};
			end
			e = {2'h0, o};
			if (i % 2 == 1 && i % 32 == 31 && o == 8'hfd)
				e = s_a;
			else if (i % 2 == 1 && o == 8'hfc)
				e = s_f;
			chk(q[i], e);
		end
	endtask
	// ****
	// Sequence
	// ****
	initial begin
		for (int i = 0; i < 14; i++)
			cfg[8 * i +: 8] = 8'h40 + i[7:0];
		step(6);
		reset_n = 1;
		step(3);
		chk({9'h0, en}, 10'h1);
		chk({7'h0, st}, 10'h1);
		chk(sym, s_k);
		link_up(0);
		scr_dis = 1;
		ovr_n = 0;
		ovr = 1;
		force_low = 1;
		step(13);
		chk({7'h0, st}, 10'h1);
		chk(sym, s_k);
		ovr = 0;
		force_low = 0;
		link_up(1);
		ins_dis = 1;
		sel = 1;
		force_low = 1;
		step(12);
		chk({7'h0, st}, 10'h1);
		force_low = 0;
		link_up(1);
		dbg = 2'h0;
		force_low = 1;
		step(14);
		q[0] = sym;
		step(1);
		chk(q[0] ^ sym, 10'h3ff);
		chk((sym == 10'h0fa || sym == 10'h305) ? 10'h0 : sym, 10'h0);
		dbg = 2'h3;
		step(3);
		chk(sym, ~s_k);
		pdn = 1;
		step(2);
		chk({9'h0, en}, 10'h0);
		end_sim;
	end
endmodule
`default_nettype wire
